/* verilog/temp_sensor_pkg.sv */
// Shared constants and types of the temperature sensor register block
package temp_sensor_pkg;

	// ----------------------------------------
	// Pointer decode
	// ----------------------------------------
	localparam logic [2:0]  PTR_TEMP       = 3'h0;
	localparam logic [2:0]  PTR_CONFIG     = 3'h1;
	localparam logic [2:0]  PTR_HYST       = 3'h2;
	localparam logic [2:0]  PTR_UPPER      = 3'h3;
	localparam logic [2:0]  PTR_ONESHOT    = 3'h4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0]  PTR_RESET      = 8'h00;
	localparam logic [15:0] TEMP_RESET     = 16'h0000;
	localparam logic [7:0]  CONFIG_RESET   = 8'h00;
	localparam logic [15:0] HYST_RESET     = 16'h4b00;
	localparam logic [15:0] UPPER_RESET    = 16'h5000;

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	localparam int          CFG_FUNC_SEL   = 7;
	localparam int          CFG_ONESHOT    = 5;
	localparam int          CFG_FQ_HI      = 4;
	localparam int          CFG_FQ_LO      = 3;
	localparam int          CFG_POLARITY   = 2;
	localparam int          CFG_INT_MODE   = 1;
	localparam int          CFG_SHUTDOWN   = 0;
	localparam logic [7:0]  CFG_WR_MASK    = 8'hbf;
	localparam logic [15:0] DATA_MASK      = 16'hfff0;
	localparam logic [3:0]  LOW_NIBBLE     = 4'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CONV_PERIOD_MS = 60;
	localparam int          CLK_SYS_MHZ    = 100;
	localparam int          CONV_PERIOD_CYC = CONV_PERIOD_MS * CLK_SYS_MHZ * 1000;
	localparam int          TIMER_W        = 23;

	// ----------------------------------------
	// Crossing messages from the link side
	// ----------------------------------------
	typedef enum logic [1:0] {
		MSG_WRITE   = 2'h0,
		MSG_ONESHOT = 2'h1,
		MSG_READ    = 2'h2
	} msg_kind_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_WAIT = 4'h2,
		S_CONV = 4'h4,
		S_CMP  = 4'h8
	} conv_state_t;

	// Faults in a row needed before the output trips
	function automatic logic [2:0] fault_limit(input logic [1:0] sel);
		unique case (sel)
			2'h0: fault_limit = 3'h1;
			2'h1: fault_limit = 3'h2;
			2'h2: fault_limit = 3'h4;
			2'h3: fault_limit = 3'h6;
		endcase
	endfunction : fault_limit

endpackage : temp_sensor_pkg

/* verilog/temp_sensor_regs.sv */
// Register set, conversion sequencer and fault queue of the temperature sensor
// Function
// RL1: Result and both limits are 16-bit left-justified 12-bit two's-complement values.
// RL2: Lowest four bits of the result always read zero.
// RL3: Code over 16 gives degrees; subtract 4096 first when negative.
// RL4: Each new result is stored, then compared to both limits.
// RL5: One-shot bit set powers down at once until a conversion is requested.
// RL6: Write to pointer 4 runs one conversion, compare, then power-down; data dropped.
// RL7: Fault queue bits select one, two, four or six faults.
// RL8: Alert trips after that many consecutive faults; a clean result restarts count.
// RL9: Write-only 8-bit pointer resets to zero, selecting the result.
// RL10: Low three pointer bits select result, config, hysteresis, upper, one-shot.
// RL11: Result ignores writes; config and both limits are read-write.
// RL12: 16-bit registers travel upper byte first, lower byte second.
// RL13: Reset values: result 0000, config 00, hysteresis 4b00, upper 5000.
// RL14: Config bit 7 picks over-temperature or bus alert function.
// RL15: With one-shot clear, a conversion starts every 60 ms.
// RL16: Config bit 2 picks active low (0) or active high (1) output.
// RL17: Config bit 1 picks comparator (0) or latched interrupt (1).
// RL18: Shutdown bit stops conversions; clearing it resumes.
// RL19: Comparator output sets at or above upper limit, clears below hysteresis.
// RL20: Interrupt output clears only after a register read and below hysteresis.
// RL21: Reading the result during conversion returns the old value undisturbed.
// RL22: Master loads the pointer before reading a register.
// RL23: Result updates only when the converter signals done.
// RL24: One-shot trigger is ignored while continuous conversion runs.
module temp_sensor_regs #(
	parameter int CONV_PERIOD = temp_sensor_pkg::CONV_PERIOD_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	output logic             conv_start,
	input  wire logic        conv_done,
	input  wire logic [11:0] conv_code,
	output logic             over_temp_output,
	output logic             over_temp_output_oe,
	input  wire logic        clk_link,
	input  wire logic        link_start,
	input  wire logic        link_rw,
	input  wire logic        link_wr_en,
	input  wire logic [7:0]  link_wr_byte,
	input  wire logic        link_rd_en,
	output logic [7:0]       link_rd_byte
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		temp_sensor_pkg::conv_state_t       state;
		logic [7:0]                         cfg;
		logic [15:0]                        hyst;
		logic [15:0]                        upper;
		logic [15:0]                        temp;
		logic [temp_sensor_pkg::TIMER_W-1:0] timer;
		logic [2:0]                         faults;
		logic                               alert;
		logic                               read_seen;
		logic                               os_pend;
		logic                               start;
		logic                               pin_oe;
		logic [1:0]                         msg_sync;
		logic                               msg_seen;
		logic [1:0]                         pub_ack_sync;
		logic                               pub_tog;
		logic [55:0]                        pub;
	} sys_t;

	typedef struct packed {
		logic [7:0]  ptr;
		logic        first;
		logic [1:0]  idx;
		logic [7:0]  hi;
		logic        msg_tog;
		temp_sensor_pkg::msg_kind_t msg_kind;
		logic [2:0]  msg_ptr;
		logic [15:0] msg_data;
		logic [1:0]  ack_sync;
		logic [1:0]  pub_sync;
		logic        pub_ack;
		logic [55:0] snap;
		logic [7:0]  rd_byte;
	} lnk_t;

	sys_t sys_q, sys_d;
	lnk_t lnk_q, lnk_d;
	logic [1:0] lrst_q;

	localparam logic [temp_sensor_pkg::TIMER_W-1:0] PERIOD_CYC =
		temp_sensor_pkg::TIMER_W'(CONV_PERIOD - 1);

	// Byte of the snapshot seen by the master at a given pointer and byte index
	function automatic logic [7:0] reg_byte(input logic [2:0] p, input logic [1:0] i,
			input logic [55:0] s);
		logic [15:0] w;
		w = 16'h0000;
		reg_byte = 8'h00;
		unique case (p)
			temp_sensor_pkg::PTR_TEMP:   w = s[55:40];
			temp_sensor_pkg::PTR_HYST:   w = s[31:16];
			temp_sensor_pkg::PTR_UPPER:  w = s[15:0];
			default:                     w = 16'h0000;
		endcase
		if (p == temp_sensor_pkg::PTR_CONFIG) begin
			reg_byte = s[39:32];
		end else begin
			reg_byte = (i == 2'h0) ? w[15:8] : w[7:0]; // RL12
		end
	endfunction : reg_byte

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	// Reset is carried into the link domain through two flops
	always_ff @(posedge clk_link) begin
		lrst_q <= {lrst_q[0], rst_b};
	end

	always_comb begin
		lnk_d = lnk_q;
		lnk_d.ack_sync = {lnk_q.ack_sync[0], sys_q.msg_seen};
		lnk_d.pub_sync = {lnk_q.pub_sync[0], sys_q.pub_tog};
		// Snapshot words are stable while the publish toggle is unacknowledged
		if (lnk_q.pub_sync[1] != lnk_q.pub_ack) begin
			lnk_d.snap = sys_q.pub;
			lnk_d.pub_ack = lnk_q.pub_sync[1];
		end
		if (link_start) begin
			lnk_d.first = !link_rw;
			lnk_d.idx = 2'h0;
			if (link_rw && lnk_q.msg_tog == lnk_q.ack_sync[1]) begin
				lnk_d.msg_kind = temp_sensor_pkg::MSG_READ;
				lnk_d.msg_tog = !lnk_q.msg_tog;
			end
		end else if (link_wr_en && lnk_q.first) begin
			lnk_d.ptr = link_wr_byte; // RL9
			lnk_d.first = 1'b0;
			lnk_d.idx = 2'h0;
			if (link_wr_byte[2:0] == temp_sensor_pkg::PTR_ONESHOT
					&& lnk_q.msg_tog == lnk_q.ack_sync[1]) begin
				lnk_d.msg_kind = temp_sensor_pkg::MSG_ONESHOT; // RL6
				lnk_d.msg_tog = !lnk_q.msg_tog;
			end
		end else if (link_wr_en) begin
			lnk_d.idx = (lnk_q.idx == 2'h2) ? lnk_q.idx : lnk_q.idx + 2'h1;
			if (lnk_q.idx == 2'h0) begin
				lnk_d.hi = link_wr_byte; // RL12
			end
			// Byte count that completes a write depends on register width
			if (lnk_q.msg_tog == lnk_q.ack_sync[1]
					&& ((lnk_q.ptr[2:0] == temp_sensor_pkg::PTR_CONFIG && lnk_q.idx == 2'h0)
					|| ((lnk_q.ptr[2:0] == temp_sensor_pkg::PTR_HYST
					|| lnk_q.ptr[2:0] == temp_sensor_pkg::PTR_UPPER) && lnk_q.idx == 2'h1))) begin
				lnk_d.msg_kind = temp_sensor_pkg::MSG_WRITE;
				lnk_d.msg_ptr = lnk_q.ptr[2:0]; // RL10
				lnk_d.msg_data = {lnk_q.hi, link_wr_byte};
				if (lnk_q.idx == 2'h0) begin
					lnk_d.msg_data = {8'h00, link_wr_byte};
				end
				lnk_d.msg_tog = !lnk_q.msg_tog;
			end
		end else if (link_rd_en) begin
			lnk_d.idx = 2'h1;
		end
		// Reads come from the snapshot, never from the converter path
		lnk_d.rd_byte = reg_byte(lnk_d.ptr[2:0], lnk_d.idx, lnk_d.snap); // RL21
	end

	always_ff @(posedge clk_link) begin
		if (!lrst_q[1]) begin
			lnk_q <= '0;
			lnk_q.ptr <= temp_sensor_pkg::PTR_RESET; // RL9
			lnk_q.snap <= {temp_sensor_pkg::TEMP_RESET, temp_sensor_pkg::CONFIG_RESET,
				temp_sensor_pkg::HYST_RESET, temp_sensor_pkg::UPPER_RESET};
		end else begin
			lnk_q <= lnk_d;
		end
	end

	// ----------------------------------------
	// System domain
	// ----------------------------------------
	logic        continuous;
	logic        fault;
	logic        below_hyst;
	logic        latched;
	logic        new_msg;
	logic [15:0] new_temp;
	logic [2:0]  limit;

	always_comb begin
		continuous = !sys_q.cfg[temp_sensor_pkg::CFG_SHUTDOWN]
			&& !sys_q.cfg[temp_sensor_pkg::CFG_ONESHOT]; // RL5 RL18
		new_temp = {conv_code, temp_sensor_pkg::LOW_NIBBLE}; // RL1 RL2
		fault = $signed(sys_q.temp) >= $signed(sys_q.upper); // RL3
		below_hyst = $signed(sys_q.temp) < $signed(sys_q.hyst);
		// Bus alert selection holds the output like interrupt mode until a read
		latched = sys_q.cfg[temp_sensor_pkg::CFG_INT_MODE]
			|| sys_q.cfg[temp_sensor_pkg::CFG_FUNC_SEL]; // RL14 RL17
		limit = temp_sensor_pkg::fault_limit(
			sys_q.cfg[temp_sensor_pkg::CFG_FQ_HI:temp_sensor_pkg::CFG_FQ_LO]); // RL7
		new_msg = sys_q.msg_sync[1] != sys_q.msg_seen;

		sys_d = sys_q;
		sys_d.start = 1'b0;
		sys_d.msg_sync = {sys_q.msg_sync[0], lnk_q.msg_tog};
		sys_d.pub_ack_sync = {sys_q.pub_ack_sync[0], lnk_q.pub_ack};

		if (new_msg) begin
			sys_d.msg_seen = sys_q.msg_sync[1];
			unique case (lnk_q.msg_kind)
				temp_sensor_pkg::MSG_WRITE: begin
					unique case (lnk_q.msg_ptr) // RL11
						temp_sensor_pkg::PTR_CONFIG:
							sys_d.cfg = lnk_q.msg_data[7:0] & temp_sensor_pkg::CFG_WR_MASK;
						temp_sensor_pkg::PTR_HYST:
							sys_d.hyst = lnk_q.msg_data & temp_sensor_pkg::DATA_MASK;
						temp_sensor_pkg::PTR_UPPER:
							sys_d.upper = lnk_q.msg_data & temp_sensor_pkg::DATA_MASK;
						default: ;
					endcase
				end
				temp_sensor_pkg::MSG_ONESHOT: begin
					if (!continuous) begin
						sys_d.os_pend = 1'b1; // RL24
					end
				end
				temp_sensor_pkg::MSG_READ: sys_d.read_seen = 1'b1;
				default: ;
			endcase
		end

		if (sys_q.state != temp_sensor_pkg::S_IDLE) begin
			sys_d.timer = (sys_q.timer == '0) ? sys_q.timer : sys_q.timer - 1'b1;
		end

		// Clears come first so that a trip in the same cycle wins
		if (!latched && below_hyst) begin
			sys_d.alert = 1'b0; // RL19
		end
		if (latched && sys_q.read_seen && below_hyst) begin
			sys_d.alert = 1'b0; // RL20
		end

		unique case (sys_q.state)
			temp_sensor_pkg::S_IDLE: begin
				if (continuous || sys_q.os_pend) begin
					sys_d.os_pend = 1'b0;
					sys_d.start = 1'b1;
					sys_d.timer = PERIOD_CYC;
					sys_d.state = temp_sensor_pkg::S_CONV;
				end
			end
			temp_sensor_pkg::S_WAIT: begin
				if (!continuous) begin
					sys_d.state = temp_sensor_pkg::S_IDLE; // RL5
				end else if (sys_q.timer == '0) begin
					sys_d.start = 1'b1; // RL15
					sys_d.timer = PERIOD_CYC;
					sys_d.state = temp_sensor_pkg::S_CONV;
				end
			end
			temp_sensor_pkg::S_CONV: begin
				if (conv_done) begin
					sys_d.temp = new_temp; // RL23 RL4
					sys_d.state = temp_sensor_pkg::S_CMP;
				end
			end
			temp_sensor_pkg::S_CMP: begin
				if (fault) begin
					// Saturate so that a smaller queue depth cannot wrap the count
					sys_d.faults = (sys_q.faults >= limit) ? limit : sys_q.faults + 3'h1;
					if (sys_q.faults + 3'h1 >= limit) begin
						sys_d.alert = 1'b1; // RL8
						sys_d.read_seen = 1'b0;
					end
				end else begin
					sys_d.faults = 3'h0; // RL8
				end
				sys_d.state = continuous ? temp_sensor_pkg::S_WAIT
					: temp_sensor_pkg::S_IDLE; // RL6
			end
			default: sys_d.state = temp_sensor_pkg::S_IDLE;
		endcase

		// Open drain: pull low whenever the pin must read low
		sys_d.pin_oe = sys_q.cfg[temp_sensor_pkg::CFG_POLARITY] ? !sys_d.alert
			: sys_d.alert; // RL16 RL14 RL17

		if (sys_q.pub_ack_sync[1] == sys_q.pub_tog) begin
			sys_d.pub = {sys_q.temp, sys_q.cfg, sys_q.hyst, sys_q.upper};
			sys_d.pub_tog = !sys_q.pub_tog;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sys_q <= '0;
			sys_q.state <= temp_sensor_pkg::S_IDLE;
			sys_q.cfg <= temp_sensor_pkg::CONFIG_RESET; // RL13
			sys_q.hyst <= temp_sensor_pkg::HYST_RESET;
			sys_q.upper <= temp_sensor_pkg::UPPER_RESET;
			sys_q.temp <= temp_sensor_pkg::TEMP_RESET;
		end else begin
			sys_q <= sys_d;
		end
	end

	assign conv_start = sys_q.start;
	assign over_temp_output = 1'b0;
	assign over_temp_output_oe = sys_q.pin_oe;
	assign link_rd_byte = lnk_q.rd_byte;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence seq_conv_done;
		sys_q.state == temp_sensor_pkg::S_CONV && conv_done;
	endsequence

	sequence seq_oneshot_msg;
		new_msg && lnk_q.msg_kind == temp_sensor_pkg::MSG_ONESHOT;
	endsequence

	sequence seq_read_msg;
		new_msg && lnk_q.msg_kind == temp_sensor_pkg::MSG_READ;
	endsequence

	a_temp_low_zero: assert property (sys_q.temp[3:0] == temp_sensor_pkg::LOW_NIBBLE) // RL2
		else $error("result low nibble not zero");
	a_conv_update: assert property (seq_conv_done |=> sys_q.temp == {$past(conv_code), 4'h0}) // RL4
		else $error("result not loaded from converter");
	a_result_hold: assert property (!(sys_q.state == temp_sensor_pkg::S_CONV && conv_done)
		|=> $stable(sys_q.temp)) // RL23
		else $error("result changed without done");
	a_shutdown_stop: assert property (sys_q.cfg[temp_sensor_pkg::CFG_SHUTDOWN]
		&& sys_q.state == temp_sensor_pkg::S_IDLE && !sys_q.os_pend |=> !sys_q.start) // RL18
		else $error("conversion started in shutdown");
	a_pin_polarity: assert property (##1 sys_q.pin_oe == (sys_q.cfg[temp_sensor_pkg::CFG_POLARITY]
		? !sys_q.alert : sys_q.alert) || $changed(sys_q.cfg)) // RL16
		else $error("pin level disagrees with polarity");
	a_cmp_clear: assert property (!latched && below_hyst
		&& sys_q.state != temp_sensor_pkg::S_CMP |=> !sys_q.alert) // RL19
		else $error("comparator output did not clear");
	a_trip_cause: assert property ($rose(sys_q.alert) |-> $past(sys_q.state == temp_sensor_pkg::S_CMP
		&& fault)) // RL8
		else $error("alert set without a fault");
	a_oneshot_back: assert property (seq_conv_done ##1 !continuous
		|=> sys_q.state == temp_sensor_pkg::S_IDLE) // RL6
		else $error("no return to power-down");
	a_period_start: assert property (sys_q.state == temp_sensor_pkg::S_CMP && continuous
		|=> sys_q.state == temp_sensor_pkg::S_WAIT) // RL15
		else $error("continuous mode did not wait");
	a_fault_restart: assert property (sys_q.state == temp_sensor_pkg::S_CMP && !fault // RL8
		|=> sys_q.faults == 3'h0)
		else $error("fault count not restarted");
	a_queue_depth: assert property ($rose(sys_q.alert) |-> sys_q.faults == limit // RL7
		|| $changed(sys_q.cfg))
		else $error("alert set before queue depth reached");
	a_oneshot_skip: assert property (seq_oneshot_msg ##0 continuous // RL24
		|=> !$rose(sys_q.os_pend))
		else $error("one-shot taken during continuous run");
	a_oneshot_arm: assert property (seq_oneshot_msg ##0 (!continuous && !sys_q.os_pend) // RL6
		|=> sys_q.os_pend)
		else $error("one-shot request not armed");
	a_read_notice: assert property (seq_read_msg ##0 sys_q.state != temp_sensor_pkg::S_CMP // RL20
		|=> sys_q.read_seen)
		else $error("register read not noted");

	// Link side checks use the link clock and the link copy of reset
	a_ptr_load: assert property (@(posedge clk_link) disable iff (!lrst_q[1]) // RL9
		link_wr_en && lnk_q.first && !link_start |=> lnk_q.ptr == $past(link_wr_byte))
		else $error("pointer not loaded from first byte");
	a_rd_order: assert property (@(posedge clk_link) disable iff (!lrst_q[1]) // RL12
		link_start && link_rw |=> lnk_q.idx == 2'h0 && !lnk_q.first)
		else $error("read did not begin at upper byte");

endmodule : temp_sensor_regs

/* verification/link_master.sv */
// Byte-level model of the two-wire bus master on the link side
module link_master (
	input  wire logic       clk_link,
	output logic            link_start,
	output logic            link_rw,
	output logic            link_wr_en,
	output logic [7:0]      link_wr_byte,
	output logic            link_rd_en,
	input  wire logic [7:0] link_rd_byte
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		link_start   = 1'b0;
		link_rw      = 1'b0;
		link_wr_en   = 1'b0;
		link_wr_byte = 8'h00;
		link_rd_en   = 1'b0;
	end

	// ----
	// Transfers
	// ----
	// Released data shows the inverse so a stale byte is never taken as new
	task automatic pulse(input logic s, input logic rw, input logic w, input logic r,
		input logic [7:0] b);
		@(negedge clk_link);
		link_start   = s;
		link_rw      = rw;
		link_wr_en   = w;
		link_rd_en   = r;
		link_wr_byte = b;
		@(negedge clk_link);
		link_start   = 1'b0;
		link_wr_en   = 1'b0;
		link_rd_en   = 1'b0;
		link_wr_byte = ~b;
		repeat (3) @(negedge clk_link);
	endtask : pulse

	task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d, input int n);
		pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		pulse(1'b0, 1'b0, 1'b1, 1'b0, ptr);
		if (n == 2) pulse(1'b0, 1'b0, 1'b1, 1'b0, d[15:8]);
		if (n > 0) pulse(1'b0, 1'b0, 1'b1, 1'b0, d[7:0]);
		// Crossing into the system domain takes several link cycles
		repeat (12) @(negedge clk_link);
	endtask : write_reg

	task automatic read_cur(input int n, output logic [15:0] v);
		v = 16'h0000;
		pulse(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
		if (n == 1) v[7:0] = link_rd_byte;
		else begin
			v[15:8] = link_rd_byte;
			pulse(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
			v[7:0] = link_rd_byte;
		end
	endtask : read_cur

	task automatic read_reg(input logic [7:0] ptr, input int n, output logic [15:0] v);
		write_reg(ptr, 16'h0000, 0);
		read_cur(n, v);
	endtask : read_reg

endmodule : link_master

/* verification/testbench.sv */
// Self-checking testbench of the temperature sensor register block
`define CHECK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("unexpected at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int PERIOD = 200;
	localparam int LIMIT  = 40000;

	logic        clk_sys;
	logic        clk_link;
	logic        rst_b;
	logic        conv_start;
	logic        conv_done;
	logic [11:0] conv_code;
	logic        over_temp_output;
	logic        over_temp_output_oe;
	logic        link_start;
	logic        link_rw;
	logic        link_wr_en;
	logic [7:0]  link_wr_byte;
	logic        link_rd_en;
	logic [7:0]  link_rd_byte;
	logic [11:0] code;
	logic [15:0] v;
	int          err_count;
	int          num_checks;
	int          cyc;
	int          conv_wait;
	int          n_start;
	int          n_done;
	int          t_last;
	int          t_prev;
	int          s;
	int          lim[4]       = '{1, 2, 4, 6};
	logic [11:0] fq_code[8]   = '{12'h100, 12'h600, 12'h600, 12'h600,
		12'h100, 12'h600, 12'h600, 12'h600};
	logic [11:0] hy_code[5]   = '{12'h4af, 12'h4ff, 12'h500, 12'h4b0, 12'h4af};
	logic        hy_exp[5]    = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [7:0]  int_cfg[2]   = '{8'h02, 8'h80};
	logic [7:0]  off_cfg[2]   = '{8'h20, 8'h01};

	temp_sensor_regs #(.CONV_PERIOD(PERIOD)) i_temp_sensor_regs (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.conv_start(conv_start),
		.conv_done(conv_done),
		.conv_code(conv_code),
		.over_temp_output(over_temp_output),
		.over_temp_output_oe(over_temp_output_oe),
		.clk_link(clk_link),
		.link_start(link_start),
		.link_rw(link_rw),
		.link_wr_en(link_wr_en),
		.link_wr_byte(link_wr_byte),
		.link_rd_en(link_rd_en),
		.link_rd_byte(link_rd_byte)
	);

	link_master master (
		.clk_link(clk_link),
		.link_start(link_start),
		.link_rw(link_rw),
		.link_wr_en(link_wr_en),
		.link_wr_byte(link_wr_byte),
		.link_rd_en(link_rd_en),
		.link_rd_byte(link_rd_byte)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		clk_link = 1'b0;
		#3;
		forever #32 clk_link = ~clk_link;
	end

	// ----
	// Converter model and hang guard
	// ----
	// Answers 20 cycles after each start; the code is taken at done time
	always @(negedge clk_sys) begin
		cyc++;
		conv_done <= (conv_wait == 1);
		conv_code <= (conv_wait == 1) ? code : ~code;
		if (conv_wait == 1) n_done++;
		if (conv_start === 1'b1) begin
			conv_wait <= 20;
			n_start++;
			t_prev = t_last;
			t_last = cyc;
		end else if (conv_wait != 0) begin
			conv_wait <= conv_wait - 1;
		end
		if (cyc == LIMIT) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (err_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic wait_conv(input int n);
		int t;
		t = n_done + n;
		wait (n_done >= t);
		repeat (6) @(negedge clk_sys);
	endtask : wait_conv

	task automatic set_cfg(input logic [7:0] c);
		master.write_reg(8'h01, {8'h00, c}, 1);
	endtask : set_cfg

	// ----
	// Tests
	// ----
	initial begin
		rst_b     = 1'b0;
		code      = 12'h000;
		// Reset spans five link edges so the link side is cleared as well
		repeat (5) @(negedge clk_link);
		@(negedge clk_sys);
		rst_b = 1'b1;
		repeat (4) @(negedge clk_link);
		master.read_cur(2, v);
		`CHECK(v, 16'h0000);
		`CHECK(over_temp_output, 1'b0);
		master.read_reg(8'h01, 1, v);
		`CHECK(v, 16'h0000);
		master.read_reg(8'h02, 2, v);
		`CHECK(v, 16'h4b00);
		master.read_reg(8'h03, 2, v);
		`CHECK(v, 16'h5000);
		master.write_reg(8'h03, 16'h55a7, 2);
		master.read_reg(8'h03, 2, v);
		`CHECK(v, 16'h55a0);
		master.write_reg(8'h03, 16'h5000, 2);
		master.write_reg(8'h00, 16'h1234, 2);
		master.read_reg(8'h00, 2, v);
		`CHECK(v, 16'h0000);
		set_cfg(8'hff);
		master.read_reg(8'h01, 1, v);
		`CHECK(v, 16'h00bf);
		set_cfg(8'h00);
		code = 12'he70;
		wait_conv(1);
		master.read_reg(8'h00, 2, v);
		`CHECK(v, 16'((-25 * 16 + 4096) * 16));
		code = 12'hfff;
		wait_conv(1);
		master.read_reg(8'h00, 2, v);
		`CHECK(v, 16'hfff0);
		for (int q = 0; q < 4; q++) begin
			set_cfg({3'h0, 2'(q), 3'h0});
			code = 12'h100;
			wait_conv(1);
			code = 12'h600;
			for (int i = 1; i <= 6; i++) begin
				wait_conv(1);
				`CHECK(over_temp_output_oe, logic'(i >= lim[q]));
			end
		end
		set_cfg(8'h10);
		foreach (fq_code[k]) begin
			code = fq_code[k];
			wait_conv(1);
		end
		`CHECK(over_temp_output_oe, 1'b0);
		set_cfg(8'h00);
		foreach (hy_code[k]) begin
			code = hy_code[k];
			wait_conv(1);
			`CHECK(over_temp_output_oe, hy_exp[k]);
		end
		set_cfg(8'h04);
		code = 12'h600;
		wait_conv(1);
		`CHECK(over_temp_output_oe, 1'b0);
		code = 12'h100;
		wait_conv(1);
		`CHECK(over_temp_output_oe, 1'b1);
		foreach (int_cfg[k]) begin
			set_cfg(int_cfg[k]);
			wait_conv(1);
			code = 12'h600;
			wait_conv(1);
			`CHECK(over_temp_output_oe, 1'b1);
			code = 12'h100;
			wait_conv(2);
			`CHECK(over_temp_output_oe, 1'b1);
			master.read_reg(8'h00, 2, v);
			wait_conv(1);
			`CHECK(over_temp_output_oe, 1'b0);
		end
		foreach (off_cfg[k]) begin
			set_cfg(off_cfg[k]);
			repeat (300) @(negedge clk_sys);
			s = n_start;
			repeat (600) @(negedge clk_sys);
			`CHECK(n_start, s);
			master.write_reg(8'h04, 16'h0001, 1);
			repeat (300) @(negedge clk_sys);
			`CHECK(n_start, s + 1);
			master.read_reg(8'h01, 1, v);
			`CHECK(v, {8'h00, off_cfg[k]});
		end
		set_cfg(8'h00);
		s = n_start;
		repeat (600) @(negedge clk_sys);
		`CHECK(n_start > s, 1'b1);
		master.write_reg(8'h04, 16'h0000, 1);
		wait_conv(2);
		`CHECK(t_last - t_prev, PERIOD);
		tally_and_finish();
	end

endmodule : testbench
